// file: bench/ppo_host_model.sv
// host receiver model sampling the parallel pixel bus
`timescale 1ns/1ns
`default_nettype none
module ppo_host_model
  import ppo_pkg::*;
(
  input wire logic                 rst_in,
  input wire logic                 pclk_in,
  input wire logic                 row_in,
  input wire logic                 frame_in,
  input wire logic [BUS_WIDTH-1:0] data_in,
  input wire logic [LSB_WIDTH-1:0] lsb_in
);
  logic [PIXEL_WIDTH-1:0] word [0:63];
  int unsigned            count;
  int unsigned            rows;
  // low bits kept even in 8-bit mode so stray values show
  always @(posedge pclk_in or posedge rst_in) begin
    if (rst_in) begin
      count = 0;
    end else if (row_in && frame_in) begin
      word[count[5:0]] = {data_in, lsb_in};
      count++;
    end
  end
  always @(posedge frame_in) rows = 0;
  always @(negedge row_in) rows++;
endmodule
`default_nettype wire

// file: bench/ppo_monitor.sv
// checker for the parallel pixel output stage
`timescale 1ns/1ns
`default_nettype none
module ppo_monitor
  import ppo_pkg::*;
(
  input wire logic                 sys_clk_in,
  input wire logic                 rst_in,
  input wire logic                 parallel_enable_n_in,
  input wire logic                 serial_select_in,
  input wire logic                 pixel_take_out,
  input wire logic [BUS_WIDTH-1:0] data_out,
  input wire logic [LSB_WIDTH-1:0] data_lsb_out,
  input wire logic                 row_active_out,
  input wire logic                 frame_active_out,
  input wire logic                 pixel_output_clock_out,
  input wire logic                 parallel_oe_out,
  input wire logic                 serial_enable_out,
  input wire logic                 streaming_out
);
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (rst_in);
  blank_zero_a: assert property (
    !row_active_out |-> data_out == BLANK_BYTE && data_lsb_out == BLANK_LSB)
    else $error("data not zero in blanking");
  row_in_frame_a: assert property (
    row_active_out |-> frame_active_out)
    else $error("row strobe outside frame");
  one_path_a: assert property (
    !(parallel_oe_out && serial_enable_out))
    else $error("both output paths on");
  idle_quiet_a: assert property (
    !streaming_out |-> !pixel_output_clock_out && !frame_active_out
      && !parallel_oe_out)
    else $error("activity while not streaming");
  take_in_row_a: assert property (
    pixel_take_out |-> row_active_out && frame_active_out)
    else $error("pixel taken outside a row");
  take_pulse_a: assert property (
    pixel_take_out |=> !pixel_take_out)
    else $error("take pulse too long");
  data_on_low_a: assert property (
    !$stable(data_out) |-> !pixel_output_clock_out)
    else $error("data moved while pixel clock high");
  enable_gate_a: assert property (
    (parallel_enable_n_in || serial_select_in) [*5] |-> !parallel_oe_out)
    else $error("parallel pins driven while disabled");
  stream_clock_a: assert property (
    $rose(streaming_out) |-> ##[1:20] pixel_output_clock_out)
    else $error("no pixel clock after stream start");
  cover property ($rose(streaming_out));
  cover property ($rose(row_active_out));
  cover property (pixel_take_out && data_lsb_out != BLANK_LSB);
endmodule
bind ppo_output_stage ppo_monitor mon (.sys_clk_in, .rst_in,
  .parallel_enable_n_in, .serial_select_in, .pixel_take_out, .data_out,
  .data_lsb_out, .row_active_out, .frame_active_out,
  .pixel_output_clock_out, .parallel_oe_out, .serial_enable_out,
  .streaming_out);
`default_nettype wire

// file: bench/ppo_output_stage_bench.sv
// self-checking bench for the parallel pixel output stage
`timescale 1ns/1ns
`default_nettype none
module ppo_output_stage_bench;
  import ppo_pkg::*;
  localparam int ROWS = 2;
  localparam logic [9:0] FIRST_PIX = 10'h135;
  localparam logic [9:0] STEP = 10'h0a7;
  logic       clk = 0, rst = 1, ref_clk = 0, boot = 1, oe_n = 0;
  logic       ser = 0, cfg = 0, wide = 0;
  logic [9:0] pix = FIRST_PIX;
  logic [7:0] dat;
  logic [1:0] lsb;
  logic       take, row, fa, pclk, poe, sen, strm;
  int         fails = 0, check_count = 0, cyc = 0;

  ppo_output_stage #(.ACTIVE_COLS(4), .HBLANK_COLS(2), .ACTIVE_ROWS(ROWS),
    .VBLANK_ROWS(1)) dut (.sys_clk_in(clk), .rst_in(rst),
    .reference_clock_in(ref_clk), .boot_select_in(boot),
    .parallel_enable_n_in(oe_n), .serial_select_in(ser),
    .config_update_in(cfg), .wide_mode_in(wide), .pixel_data_in(pix),
    .pixel_take_out(take), .data_out(dat), .data_lsb_out(lsb),
    .row_active_out(row), .frame_active_out(fa),
    .pixel_output_clock_out(pclk), .parallel_oe_out(poe),
    .serial_enable_out(sen), .streaming_out(strm));
  ppo_host_model host (.rst_in(rst), .pclk_in(pclk), .row_in(row),
    .frame_in(fa), .data_in(dat), .lsb_in(lsb));

  initial forever #10 clk = ~clk;
  // edges fall on falling system edges; kept slow so the sampler
  // catches every level, the real reference range is beyond it
  initial forever #80 ref_clk = ~ref_clk;
  always @(negedge clk) pix <= rst ? FIRST_PIX : take ? pix + STEP : pix;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 30000) begin
      fails++;
      wrap_up();
    end
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic do_reset;
    @(negedge clk) rst = 1;
    repeat (2) @(negedge clk);
    rst = 0;
  endtask
  task automatic wait_stream;
    for (int i = 0; i < 40 && strm !== 1'b1; i++) @(negedge clk);
  endtask

  task automatic run_mode(input logic w);
    logic [9:0] e;
    @(negedge clk);
    wide = w;
    boot = 1;
    do_reset();
    wait_stream();
    chk(strm, 1);
    chk(poe, 1);
    for (int i = 0; i < 3000 && host.count < 16; i++) @(negedge clk);
    e = FIRST_PIX;
    for (int i = 0; i < 16; i++) begin
      chk(host.word[i], w ? e : {e[7:0], 2'b00});
      e = e + STEP;
    end
    @(negedge fa);
    chk(16'(host.rows), 16'(ROWS));
    $display("mode test done, wide %0d", w);
  endtask
  task automatic standby_test;
    @(negedge clk);
    boot = 0;
    do_reset();
    repeat (200) @(negedge clk);
    chk(strm, 0);
    chk(16'(host.count), 0);
    cfg = 1;
    @(negedge clk) cfg = 0;
    wait_stream();
    chk(strm, 1);
    boot = 1;
    $display("standby test done");
  endtask
  task automatic gate_test;
    oe_n = 1;
    repeat (6) @(negedge clk);
    chk(poe, 0);
    oe_n = 0;
    repeat (6) @(negedge clk);
    chk(poe, 1);
    ser = 1;
    repeat (6) @(negedge clk);
    chk({poe, sen}, 2'b01);
    ser = 0;
    $display("gate test done");
  endtask
  task automatic wrap_up;
    $display("checks %0d, mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  initial begin
    run_mode(0);
    run_mode(1);
    standby_test();
    gate_test();
    wrap_up();
  end
endmodule
`default_nettype wire

// file: logic/ppo_output_stage.sv
// parallel pixel output stage: boot select, framing strobes, data lanes
`timescale 1ns/1ns
`default_nettype none

module ppo_output_stage
  import ppo_pkg::*;
#(
  parameter int unsigned ACTIVE_COLS = DEF_ACTIVE_COLS,
  parameter int unsigned HBLANK_COLS = DEF_HBLANK_COLS,
  parameter int unsigned ACTIVE_ROWS = DEF_ACTIVE_ROWS,
  parameter int unsigned VBLANK_ROWS = DEF_VBLANK_ROWS
) (
  input  wire logic                   sys_clk_in,
  input  wire logic                   rst_in,
  input  wire logic                   reference_clock_in,
  input  wire logic                   boot_select_in,
  input  wire logic                   parallel_enable_n_in,
  input  wire logic                   serial_select_in,
  input  wire logic                   config_update_in,
  input  wire logic                   wide_mode_in,
  input  wire logic [PIXEL_WIDTH-1:0] pixel_data_in,
  output logic                        pixel_take_out,
  output logic [BUS_WIDTH-1:0]        data_out,
  output logic [LSB_WIDTH-1:0]        data_lsb_out,
  output logic                        row_active_out,
  output logic                        frame_active_out,
  output logic                        pixel_output_clock_out,
  output logic                        parallel_oe_out,
  output logic                        serial_enable_out,
  output logic                        streaming_out
);

  ppo_timing_if tim ();

  // pin synchronisers; first stage is read only by the second
  logic ref_meta;
  logic ref_sync;
  logic ref_prev;
  logic boot_meta;
  logic boot_sync;
  logic oe_n_meta;
  logic oe_n_sync;
  logic ser_meta;
  logic ser_sync;

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      ref_meta  <= 1'b0;
      ref_sync  <= 1'b0;
      ref_prev  <= 1'b0;
    end else begin
      ref_meta  <= reference_clock_in;
      ref_sync  <= ref_meta;
      ref_prev  <= ref_sync;
    end
  end

  // pull-up default: reset value matches an open boot-select pin
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      boot_meta <= BOOT_STREAM;
      boot_sync <= BOOT_STREAM;
      oe_n_meta <= 1'b1;
      oe_n_sync <= 1'b1;
      ser_meta  <= 1'b0;
      ser_sync  <= 1'b0;
    end else begin
      boot_meta <= boot_select_in;
      boot_sync <= boot_meta;
      oe_n_meta <= parallel_enable_n_in;
      oe_n_sync <= oe_n_meta;
      ser_meta  <= serial_select_in;
      ser_sync  <= ser_meta;
    end
  end

  // pixels launch on the falling edge so they are stable at the rising one
  logic ref_fall;
  assign ref_fall = ref_prev & ~ref_sync;

  // boot decision, taken once the synchroniser has settled after reset
  ppo_state_type state;
  logic [1:0]    settle;

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      settle <= '0;
    end else if (state == PPO_BOOT && settle != BOOT_SETTLE) begin
      settle <= settle + 1'b1;
    end
  end

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      state <= PPO_BOOT;
    end else begin
      case (state)
        PPO_BOOT: begin
          if (settle == BOOT_SETTLE) begin
            if (boot_sync == BOOT_STREAM) begin
              state <= PPO_STREAM;
            end else begin
              state <= PPO_STANDBY;
            end
          end
        end
        PPO_STANDBY: begin
          // standby holds until the host pushes new configuration
          if (config_update_in) begin
            state <= PPO_STREAM;
          end
        end
        PPO_STREAM: begin
          state <= PPO_STREAM;
        end
        default: begin
          state <= PPO_BOOT;
        end
      endcase
    end
  end

  logic streaming;
  assign streaming = (state == PPO_STREAM);

  // the raster restarts from row zero whenever streaming begins
  assign tim.run  = streaming;
  assign tim.step = ref_fall;

  ppo_raster_gen #(
    .ACTIVE_COLS (ACTIVE_COLS),
    .HBLANK_COLS (HBLANK_COLS),
    .ACTIVE_ROWS (ACTIVE_ROWS),
    .VBLANK_ROWS (VBLANK_ROWS)
  ) u_raster (
    .sys_clk_in (sys_clk_in),
    .rst_in     (rst_in),
    .tim        (tim)
  );

  // width mode is latched per frame so a frame never mixes formats
  logic wide_frame;

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      wide_frame <= 1'b0;
    end else if (!streaming || (ref_fall && tim.frame_end)) begin
      wide_frame <= wide_mode_in;
    end
  end

  logic launch;
  assign launch = streaming && ref_fall;

  // strobes
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      row_active_out   <= 1'b0;
      frame_active_out <= 1'b0;
    end else if (!streaming) begin
      row_active_out   <= 1'b0;
      frame_active_out <= 1'b0;
    end else if (launch) begin
      row_active_out   <= tim.pixel_slot;
      frame_active_out <= tim.frame_slot;
    end
  end

  // data lanes
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      data_out     <= BLANK_BYTE;
      data_lsb_out <= BLANK_LSB;
    end else if (!streaming) begin
      data_out     <= BLANK_BYTE;
      data_lsb_out <= BLANK_LSB;
    end else if (launch) begin
      if (!tim.pixel_slot) begin
        data_out     <= BLANK_BYTE;
        data_lsb_out <= BLANK_LSB;
      end else if (wide_frame) begin
        data_out     <= pixel_data_in[PIX_HI_MSB:PIX_HI_LSB];
        data_lsb_out <= pixel_data_in[PIX_LO_MSB:0];
      end else begin
        data_out     <= pixel_data_in[PIX_BYTE_MSB:0];
        data_lsb_out <= BLANK_LSB;
      end
    end
  end

  // one-cycle pulse telling the source its pixel was taken
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      pixel_take_out <= 1'b0;
    end else begin
      pixel_take_out <= launch && tim.pixel_slot;
    end
  end

  // pixel clock follows the reference; host samples on its rising edge
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      pixel_output_clock_out <= 1'b0;
    end else begin
      pixel_output_clock_out <= streaming & ref_sync;
    end
  end

  // path select: the parallel drivers stay off while serial is chosen,
  // and without the host's enable the bus floats
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      parallel_oe_out   <= 1'b0;
      serial_enable_out <= 1'b0;
      streaming_out     <= 1'b0;
    end else begin
      parallel_oe_out   <= streaming & ~ser_sync & ~oe_n_sync;
      serial_enable_out <= streaming & ser_sync;
      streaming_out     <= streaming;
    end
  end

endmodule

`default_nettype wire

// file: logic/ppo_pkg.sv
// shared constants for the parallel pixel output stage
package ppo_pkg;

  // input pixel width and output bus widths
  localparam int unsigned PIXEL_WIDTH   = 10;
  localparam int unsigned BUS_WIDTH     = 8;
  localparam int unsigned LSB_WIDTH     = 2;

  // field positions inside a 10-bit pixel
  localparam int unsigned PIX_HI_MSB    = 9;
  localparam int unsigned PIX_HI_LSB    = 2;
  localparam int unsigned PIX_LO_MSB    = 1;
  localparam int unsigned PIX_BYTE_MSB  = 7;

  // default raster geometry, in pixel clocks and rows
  localparam int unsigned DEF_ACTIVE_COLS = 16;
  localparam int unsigned DEF_HBLANK_COLS = 4;
  localparam int unsigned DEF_ACTIVE_ROWS = 8;
  localparam int unsigned DEF_VBLANK_ROWS = 2;
  localparam int unsigned COUNT_WIDTH     = 16;

  // boot-select level that means stream at power-up
  localparam logic BOOT_STREAM = 1'b1;

  // cycles the boot-select synchroniser needs before it is trusted
  localparam logic [1:0] BOOT_SETTLE = 2'h3;

  // blanking value on the data lines
  localparam logic [BUS_WIDTH-1:0] BLANK_BYTE = 8'h00;
  localparam logic [LSB_WIDTH-1:0] BLANK_LSB  = 2'h0;

  typedef enum logic [2:0] {
    PPO_BOOT    = 3'b001,
    PPO_STANDBY = 3'b010,
    PPO_STREAM  = 3'b100
  } ppo_state_type;

endpackage

// file: logic/ppo_raster_gen.sv
// raster counter: active region, horizontal and vertical blanking
`timescale 1ns/1ns
`default_nettype none

module ppo_raster_gen
  import ppo_pkg::*;
#(
  parameter int unsigned ACTIVE_COLS = DEF_ACTIVE_COLS,
  parameter int unsigned HBLANK_COLS = DEF_HBLANK_COLS,
  parameter int unsigned ACTIVE_ROWS = DEF_ACTIVE_ROWS,
  parameter int unsigned VBLANK_ROWS = DEF_VBLANK_ROWS
) (
  input  wire logic   sys_clk_in,
  input  wire logic   rst_in,
  ppo_timing_if.gen   tim
);

  localparam logic [COUNT_WIDTH-1:0] COL_ACT  = COUNT_WIDTH'(ACTIVE_COLS);
  localparam logic [COUNT_WIDTH-1:0] COL_LAST =
    COUNT_WIDTH'(ACTIVE_COLS + HBLANK_COLS - 1);
  localparam logic [COUNT_WIDTH-1:0] ROW_ACT  = COUNT_WIDTH'(ACTIVE_ROWS);
  localparam logic [COUNT_WIDTH-1:0] ROW_LAST =
    COUNT_WIDTH'(ACTIVE_ROWS + VBLANK_ROWS - 1);

  logic [COUNT_WIDTH-1:0] col;
  logic [COUNT_WIDTH-1:0] row;

  // rows in order, no field interleave
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      col <= '0;
      row <= '0;
    end else if (!tim.run) begin
      col <= '0;
      row <= '0;
    end else if (tim.step) begin
      if (col == COL_LAST) begin
        col <= '0;
        row <= (row == ROW_LAST) ? '0 : row + 1'b1;
      end else begin
        col <= col + 1'b1;
      end
    end
  end

  // hblank after each row, vblank after the last row
  assign tim.pixel_slot = (row < ROW_ACT) && (col < COL_ACT);
  assign tim.frame_slot = (row < ROW_ACT);
  assign tim.frame_end  = (row == ROW_LAST) && (col == COL_LAST);

endmodule

`default_nettype wire

// file: logic/ppo_timing_if.sv
// raster position carrier between the output stage and its raster counter
`timescale 1ns/1ns
`default_nettype none

interface ppo_timing_if;
  logic run;
  logic step;
  logic pixel_slot;
  logic frame_slot;
  logic frame_end;

  modport gen (
    input  run,
    input  step,
    output pixel_slot,
    output frame_slot,
    output frame_end
  );

  modport use_side (
    output run,
    output step,
    input  pixel_slot,
    input  frame_slot,
    input  frame_end
  );
endinterface

`default_nettype wire
